//--- hdl/dummy_removed_placeholder.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

//--- hdl/queued_cmd_pkg.sv
// Purpose: Shared constants and types for the queued send command link.
// Assumes: One clock shared by the controller and the device end.
// Notes: Shadow register bytes travel as one packed word per command.
package queued_cmd_pkg;
  // Command opcode and subcommand codes.
  localparam logic [7:0] OPCODE_SEND_QUEUED = 8'h64;
  localparam logic [4:0] SUBCMD_WRITE_LOG = 5'h02;
  // Field positions inside the shadow bytes.
  localparam int TAG_LSB = 3;
  localparam int SUBCMD_MSB = 4;
  localparam int DEVHEAD_LBA_BIT = 6;
  localparam int DEVHEAD_DEV_BIT = 4;
  // Status byte bit positions.
  localparam int STAT_BSY = 7;
  localparam int STAT_RDY = 6;
  localparam int STAT_ERR = 0;
  // Error byte bit position for an aborted command.
  localparam int ERR_ABT = 2;
  localparam logic [7:0] ERR_ABORT_CODE = 8'h04;
  // Reset values of the reported bytes.
  localparam logic [7:0] STATE_FLAGS_RESET = 8'h40;
  localparam logic [7:0] ERROR_FLAGS_RESET = 8'h00;
  // Controller register byte offsets on the AHB-Lite bus.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_COUNT = 8'h04;
  localparam logic [7:0] OFS_LBA_LO = 8'h08;
  localparam logic [7:0] OFS_LBA_HI = 8'h0C;
  localparam logic [7:0] OFS_CMD = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h1C;
  localparam logic [7:0] OFS_IRQ_EN = 8'h20;
  localparam logic [7:0] OFS_DONE = 8'h24;
  localparam logic [7:0] OFS_DONE_CLR = 8'h28;
  // Interrupt status bit positions.
  localparam int IRQ_ACCEPT = 0;
  localparam int IRQ_ERROR = 1;
  localparam int IRQ_DONE = 2;
  // Reset value of the opcode field of the command register.
  localparam logic [7:0] CMD_OPCODE_RESET = OPCODE_SEND_QUEUED;

  // Kinds of frame sent from the device to the host.
  typedef enum logic [1:0] {
    FIS_NONE = 2'b00,
    FIS_REG_D2H = 2'b01,
    FIS_SET_BITS = 2'b10
  } fis_kind_t;

  // Shadow register image of one command, current and previous bytes.
  typedef struct packed {
    logic [7:0] command;
    logic [7:0] devhead;
    logic [7:0] feat_cur;
    logic [7:0] feat_prev;
    logic [7:0] cnt_cur;
    logic [7:0] cnt_prev;
    logic [7:0] sec_cur;
    logic [7:0] sec_prev;
    logic [7:0] cyllo_cur;
    logic [7:0] cyllo_prev;
    logic [7:0] cylhi_cur;
    logic [7:0] cylhi_prev;
  } shadow_t;
endpackage

//--- hdl/queued_link_if.sv
// Purpose: Link between the queued command controller and the device end.
// Assumes: Both ends run on the same clock.
// Notes: Commands use valid and ready; frames are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
interface queued_link_if;
  import queued_cmd_pkg::*;
  logic cmd_valid; // Command image is offered.
  logic cmd_ready; // Device can take a command.
  shadow_t cmd; // Shadow register image.
  logic fis_valid; // Frame pulse from the device.
  fis_kind_t fis_kind; // Kind of the frame.
  logic [7:0] fis_status; // Status byte of a register frame.
  logic [7:0] fis_error; // Error byte of a register frame.
  logic [31:0] fis_act; // Completed tag bits of a set bits frame.

  // Controller end.
  modport host (output cmd_valid, output cmd, input cmd_ready,
    input fis_valid, input fis_kind, input fis_status, input fis_error, input fis_act);
  // Device end.
  modport device (input cmd_valid, input cmd, output cmd_ready,
    output fis_valid, output fis_kind, output fis_status, output fis_error, output fis_act);
endinterface
`default_nettype wire

//--- hdl/queued_log_dev.sv
// Purpose: Device end that decodes the queued send command and reports results.
// Assumes: The user side accepts or refuses each decoded job and returns tags.
// Notes: A refused or undecodable command is answered by a register frame.
//
// Our own choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module queued_log_dev
  import queued_cmd_pkg::*;
(
  input wire logic clk_i, // System clock.
  input wire logic rst_n_i, // Asynchronous reset, active low.
  queued_link_if.device link, // Link to the controller.
  output logic job_valid_o, // Decoded job waits for the user side.
  output logic [4:0] job_tag_o, // Queue tag of the job.
  output logic [15:0] job_count_o, // Transfer count of the job.
  output logic [47:0] job_lba_o, // Log address of the job.
  input wire logic job_accept_i, // User side takes the job.
  input wire logic job_error_i, // User side refuses the job.
  input wire logic [7:0] job_error_code_i, // Error byte for a refusal.
  input wire logic done_valid_i, // A queued job has finished.
  input wire logic [4:0] done_tag_i, // Tag of the finished job.
  output logic [31:0] outstanding_o, // Tags accepted and not finished.
  output logic [7:0] error_flags_o, // Error byte last reported.
  output logic [7:0] device_state_flags_o // Status byte now shown.
);

  // Control states, one-hot.
  typedef enum logic [1:0] {
    DEV_IDLE = 2'b01,
    DEV_BUSY = 2'b10
  } dev_state_t;

  // Whole state of the device end.
  typedef struct packed {
    dev_state_t st; // Control state.
    logic cmd_ready; // Ready to take a command.
    logic job_valid; // Job offered to the user side.
    logic [4:0] tag; // Tag of the held job.
    logic [15:0] count; // Count of the held job.
    logic [47:0] lba; // Log address of the held job.
    logic [31:0] outstanding; // Accepted, unfinished tags.
    logic [31:0] pending; // Finished tags not yet reported.
    logic fis_valid; // Frame pulse.
    fis_kind_t fis_kind; // Frame kind.
    logic [7:0] fis_status; // Frame status byte.
    logic [7:0] fis_error; // Frame error byte.
    logic [31:0] fis_act; // Frame tag bits.
    logic [7:0] err_flags; // Error byte last reported.
    logic [7:0] state_flags; // Status byte now shown.
  } dev_regs_t;

  dev_regs_t r_r; // Registered state.
  dev_regs_t r_nxt; // Next state.

  // Pulls the queue tag out of a command image.
  function automatic logic [4:0] tag_of(input shadow_t s);
    tag_of = s.cnt_cur[7:TAG_LSB];
  endfunction

  // Pulls the subcommand out of a command image.
  function automatic logic [4:0] subcmd_of(input shadow_t s);
    subcmd_of = s.cnt_prev[SUBCMD_MSB:0];
  endfunction

  // Builds a status byte with busy clear and the error bit as given.
  function automatic logic [7:0] status_byte(input logic err);
    logic [7:0] v;
    v = 8'h00;
    v[STAT_RDY] = 1'b1;
    v[STAT_ERR] = err;
    status_byte = v;
  endfunction

  // Next-state logic for decode, acceptance, refusal and completion.
  always_comb
  begin
    logic [4:0] t;
    logic op_ok;
    logic sub_ok;
    t = tag_of(link.cmd);
    op_ok = (link.cmd.command == OPCODE_SEND_QUEUED);
    sub_ok = (subcmd_of(link.cmd) == SUBCMD_WRITE_LOG);
    r_nxt = r_r;
    r_nxt.fis_valid = 1'b0;
    r_nxt.fis_kind = FIS_NONE;
    // A finished tag moves from outstanding to pending.
    if (done_valid_i && r_r.outstanding[done_tag_i])
    begin
      r_nxt.outstanding[done_tag_i] = 1'b0;
      r_nxt.pending[done_tag_i] = 1'b1;
    end
    case (r_r.st)
      DEV_IDLE:
      begin
        // A new command is taken only while ready.
        if (link.cmd_valid && r_r.cmd_ready)
        begin
          r_nxt.tag = t;
          r_nxt.count = {link.cmd.feat_prev, link.cmd.feat_cur};
          r_nxt.lba = {link.cmd.cylhi_prev, link.cmd.cyllo_prev, link.cmd.sec_prev,
            link.cmd.cylhi_cur, link.cmd.cyllo_cur, link.cmd.sec_cur};
          if (op_ok && sub_ok && !r_r.outstanding[t])
          begin
            // Known operation: hold busy and offer the job.
            r_nxt.st = DEV_BUSY;
            r_nxt.job_valid = 1'b1;
            r_nxt.state_flags[STAT_BSY] = 1'b1;
          end
          else
          begin
            // Reserved subcommand, wrong opcode or tag in use: abort.
            r_nxt.fis_valid = 1'b1;
            r_nxt.fis_kind = FIS_REG_D2H;
            r_nxt.fis_status = status_byte(1'b1);
            r_nxt.fis_error = ERR_ABORT_CODE;
            r_nxt.err_flags = ERR_ABORT_CODE;
            r_nxt.state_flags = status_byte(1'b1);
          end
        end
      end
      DEV_BUSY:
      begin
        // Refusal wins over acceptance if both arrive together.
        if (job_error_i)
        begin
          r_nxt.st = DEV_IDLE;
          r_nxt.job_valid = 1'b0;
          r_nxt.fis_valid = 1'b1;
          r_nxt.fis_kind = FIS_REG_D2H;
          r_nxt.fis_status = status_byte(1'b1);
          r_nxt.fis_error = job_error_code_i;
          r_nxt.err_flags = job_error_code_i;
          r_nxt.state_flags = status_byte(1'b1);
        end
        else if (job_accept_i)
        begin
          // Clearing busy acknowledges the command.
          r_nxt.st = DEV_IDLE;
          r_nxt.job_valid = 1'b0;
          r_nxt.outstanding[r_r.tag] = 1'b1;
          r_nxt.fis_valid = 1'b1;
          r_nxt.fis_kind = FIS_REG_D2H;
          r_nxt.fis_status = status_byte(1'b0);
          r_nxt.fis_error = 8'h00;
          r_nxt.err_flags = 8'h00;
          r_nxt.state_flags = status_byte(1'b0);
        end
      end
      default:
      begin
        r_nxt.st = DEV_IDLE;
        r_nxt.job_valid = 1'b0;
      end
    endcase
    // Completions wait for a free frame slot, then go out together.
    if (!r_nxt.fis_valid && (r_r.pending != 32'h0000_0000))
    begin
      r_nxt.fis_valid = 1'b1;
      r_nxt.fis_kind = FIS_SET_BITS;
      r_nxt.fis_act = r_r.pending;
      r_nxt.fis_status = r_r.state_flags;
      r_nxt.fis_status[STAT_BSY] = 1'b0; // Never busy in a completion frame.
      r_nxt.fis_error = r_r.err_flags;
      // Tags finishing in this same cycle stay pending.
      r_nxt.pending = r_nxt.pending & ~r_r.pending;
    end
    else if (r_nxt.fis_valid)
    begin
      r_nxt.fis_act = 32'h0000_0000;
    end
    r_nxt.cmd_ready = (r_nxt.st == DEV_IDLE);
  end

  // State register; reset leaves the device idle and ready.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      r_r <= '0;
      r_r.st <= DEV_IDLE;
      r_r.cmd_ready <= 1'b1;
      r_r.fis_kind <= FIS_NONE;
      r_r.err_flags <= ERROR_FLAGS_RESET;
      r_r.state_flags <= STATE_FLAGS_RESET;
    end
    else
    begin
      r_r <= r_nxt;
    end
  end

  // Link outputs, all straight from the state register.
  assign link.cmd_ready = r_r.cmd_ready;
  assign link.fis_valid = r_r.fis_valid;
  assign link.fis_kind = r_r.fis_kind;
  assign link.fis_status = r_r.fis_status;
  assign link.fis_error = r_r.fis_error;
  assign link.fis_act = r_r.fis_act;

  // User-side outputs, also straight from the state register.
  assign job_valid_o = r_r.job_valid;
  assign job_tag_o = r_r.tag;
  assign job_count_o = r_r.count;
  assign job_lba_o = r_r.lba;
  assign outstanding_o = r_r.outstanding;
  assign error_flags_o = r_r.err_flags;
  assign device_state_flags_o = r_r.state_flags;

endmodule
`default_nettype wire

//--- hdl/queued_log_host.sv
// Purpose: Controller that issues queued send commands ordered over AHB-Lite.
// Assumes: One slave on the bus; single word transfers only.
// Notes: Zero wait states; read data is sampled in the address phase.
`timescale 1ns/1ps
`default_nettype none
module queued_log_host
  import queued_cmd_pkg::*;
(
  input wire logic clk_i, // System clock.
  input wire logic rst_n_i, // Asynchronous reset, active low.
  input wire logic hsel_i, // Slave select.
  input wire logic [31:0] haddr_i, // Byte address.
  input wire logic [1:0] htrans_i, // Transfer type.
  input wire logic hwrite_i, // Write when high.
  input wire logic [2:0] hsize_i, // Transfer size, word only.
  input wire logic hready_i, // Bus ready.
  input wire logic [31:0] hwdata_i, // Write data.
  output logic [31:0] hrdata_o, // Read data.
  output logic hreadyout_o, // Slave ready.
  output logic hresp_o, // Response, always OKAY.
  output logic irq_o, // Level interrupt.
  queued_link_if.host link // Link to the device.
);

  // Whole state of the controller.
  typedef struct packed {
    logic dp_write; // Write data phase pending.
    logic [7:0] dp_addr; // Address of that write.
    logic [31:0] hrdata; // Read data for the data phase.
    logic [15:0] count; // Transfer count.
    logic [47:0] lba; // Log address.
    logic [4:0] tag; // Queue tag.
    logic [4:0] sub; // Subcommand.
    logic [7:0] opcode; // Command opcode.
    logic busy; // Command issued, no register frame yet.
    logic cmd_valid; // Command offered on the link.
    shadow_t cmd; // Command image.
    logic [7:0] last_status; // Status byte last received.
    logic [7:0] last_error; // Error byte last received.
    logic [2:0] irq_stat; // Sticky events.
    logic [2:0] irq_en; // Event enables.
    logic [31:0] done; // Completed tags seen.
    logic irq; // Interrupt level.
  } host_regs_t;

  host_regs_t r_r; // Registered state.
  host_regs_t r_nxt; // Next state.

  // Read view of a register; unmapped and write-only read as zero.
  function automatic logic [31:0] rd(input host_regs_t s, input logic [7:0] a);
    case (a)
      OFS_COUNT: rd = {16'h0000, s.count};
      OFS_LBA_LO: rd = s.lba[31:0];
      OFS_LBA_HI: rd = {16'h0000, s.lba[47:32]};
      OFS_CMD: rd = {8'h00, s.opcode, 3'b000, s.sub, 3'b000, s.tag};
      OFS_STATUS: rd = {15'h0000, s.busy, s.last_error, s.last_status};
      OFS_IRQ_STAT: rd = {29'h0000_0000, s.irq_stat};
      OFS_IRQ_EN: rd = {29'h0000_0000, s.irq_en};
      OFS_DONE: rd = s.done;
      default: rd = 32'h0000_0000;
    endcase
  endfunction

  // Next-state logic for the bus slave, command issue and frame intake.
  always_comb
  begin
    logic take;
    logic [2:0] set;
    logic [2:0] clr;
    logic [31:0] done_clr;
    logic go;
    take = hsel_i && htrans_i[1] && hready_i;
    set = 3'b000;
    clr = 3'b000;
    done_clr = 32'h0000_0000;
    go = 1'b0;
    r_nxt = r_r;
    // Address phase: note writes, sample reads.
    r_nxt.dp_write = take && hwrite_i;
    r_nxt.dp_addr = {haddr_i[7:2], 2'b00};
    if (take && !hwrite_i)
    begin
      r_nxt.hrdata = rd(r_r, {haddr_i[7:2], 2'b00});
    end
    // Data phase of a write.
    if (r_r.dp_write)
    begin
      case (r_r.dp_addr)
        OFS_CTRL: go = hwdata_i[0];
        OFS_COUNT: r_nxt.count = hwdata_i[15:0];
        OFS_LBA_LO: r_nxt.lba[31:0] = hwdata_i;
        OFS_LBA_HI: r_nxt.lba[47:32] = hwdata_i[15:0];
        OFS_CMD:
        begin
          r_nxt.tag = hwdata_i[4:0];
          r_nxt.sub = hwdata_i[12:8];
          r_nxt.opcode = hwdata_i[23:16];
        end
        OFS_IRQ_CLR: clr = hwdata_i[2:0];
        OFS_IRQ_EN: r_nxt.irq_en = hwdata_i[2:0];
        OFS_DONE_CLR: done_clr = hwdata_i;
        default: go = 1'b0;
      endcase
    end
    // Start is ignored while a command is still unanswered.
    if (go && !r_r.busy)
    begin
      r_nxt.busy = 1'b1;
      r_nxt.cmd_valid = 1'b1;
      r_nxt.cmd.command = r_r.opcode;
      r_nxt.cmd.devhead = 8'h00;
      r_nxt.cmd.devhead[DEVHEAD_LBA_BIT] = 1'b1;
      r_nxt.cmd.devhead[DEVHEAD_DEV_BIT] = 1'b0;
      r_nxt.cmd.feat_cur = r_r.count[7:0];
      r_nxt.cmd.feat_prev = r_r.count[15:8];
      r_nxt.cmd.cnt_cur = {r_r.tag, 3'b000};
      r_nxt.cmd.cnt_prev = {3'b000, r_r.sub};
      r_nxt.cmd.sec_cur = r_r.lba[7:0];
      r_nxt.cmd.cyllo_cur = r_r.lba[15:8];
      r_nxt.cmd.cylhi_cur = r_r.lba[23:16];
      r_nxt.cmd.sec_prev = r_r.lba[31:24];
      r_nxt.cmd.cyllo_prev = r_r.lba[39:32];
      r_nxt.cmd.cylhi_prev = r_r.lba[47:40];
    end
    else if (r_r.cmd_valid && link.cmd_ready)
    begin
      r_nxt.cmd_valid = 1'b0;
    end
    // Frame intake.
    if (link.fis_valid && (link.fis_kind == FIS_REG_D2H))
    begin
      r_nxt.busy = 1'b0;
      r_nxt.last_status = link.fis_status;
      r_nxt.last_error = link.fis_error;
      set[IRQ_ACCEPT] = !link.fis_status[STAT_ERR];
      set[IRQ_ERROR] = link.fis_status[STAT_ERR];
    end
    if (link.fis_valid && (link.fis_kind == FIS_SET_BITS))
    begin
      set[IRQ_DONE] = 1'b1;
    end
    // Set wins over clear for every sticky bit.
    r_nxt.irq_stat = (r_r.irq_stat & ~clr) | set;
    r_nxt.done = (r_r.done & ~done_clr) |
      ((link.fis_valid && (link.fis_kind == FIS_SET_BITS)) ? link.fis_act : 32'h0000_0000);
    r_nxt.irq = |(r_nxt.irq_stat & r_nxt.irq_en);
  end

  // State register.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      r_r <= '0;
      r_r.opcode <= CMD_OPCODE_RESET;
    end
    else
    begin
      r_r <= r_nxt;
    end
  end

  // Outputs straight from the state register, except the constant ready and response.
  assign hrdata_o = r_r.hrdata;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign irq_o = r_r.irq;
  assign link.cmd_valid = r_r.cmd_valid;
  assign link.cmd = r_r.cmd;

endmodule
`default_nettype wire

//--- sim/queued_log_sva.sv
// Purpose: Assertions on the link that joins the two queued command ends.
// Assumes: One clock and one reset; every other input is a link signal taken as it is.
// Notes: Instantiated once in the bench top beside the link.
`timescale 1ns/1ps
`default_nettype none
module queued_log_sva
  import queued_cmd_pkg::*;
(
  input wire logic clk_i, // System clock.
  input wire logic rst_n_i, // Reset, active low.
  input wire logic cmd_valid, // Command offered.
  input wire logic cmd_ready, // Device idle.
  input wire shadow_t cmd, // Command image.
  input wire logic fis_valid, // Frame pulse.
  input wire fis_kind_t fis_kind, // Frame kind.
  input wire logic [7:0] fis_status, // Status byte.
  input wire logic [7:0] fis_error, // Error byte.
  input wire logic [31:0] fis_act // Completed tag bits.
);
  // All checks share the one clock and are idle in reset.
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // A command changes hands on this edge.
  sequence s_take;
    cmd_valid && cmd_ready;
  endsequence
  // A register frame, which closes the command in flight.
  sequence s_reg_frame;
    fis_valid && fis_kind == FIS_REG_D2H;
  endsequence
  // A register frame that reports an aborted command.
  sequence s_abort;
    s_reg_frame ##0 (fis_status[STAT_ERR] && fis_error == ERR_ABORT_CODE);
  endsequence
  a_bad_opcode_abort: assert property (
    s_take ##0 (cmd.command != OPCODE_SEND_QUEUED) |=> s_abort)
    else $error("foreign opcode not aborted next cycle");
  a_bad_subcmd_abort: assert property (
    s_take ##0 (cmd.command == OPCODE_SEND_QUEUED
      && cmd.cnt_prev[SUBCMD_MSB:0] != SUBCMD_WRITE_LOG) |=> s_abort)
    else $error("reserved subcommand not aborted next cycle");
  a_answer_bound: assert property (
    s_take |-> ##[1:40] s_reg_frame)
    else $error("taken command never answered by a register frame");
  a_one_in_flight: assert property (
    s_take |=> !(cmd_valid && cmd_ready) until s_reg_frame)
    else $error("second command taken before the first was answered");
  a_reg_no_act: assert property (
    s_reg_frame |-> fis_act == 32'h0000_0000)
    else $error("register frame carries completion bits");
  a_setbits_act: assert property (
    fis_valid && fis_kind == FIS_SET_BITS |-> fis_act != 32'h0000_0000)
    else $error("completion frame with no tag bit");
  a_frame_not_busy: assert property (
    fis_valid |-> !fis_status[STAT_BSY])
    else $error("frame reports busy set");
  a_good_status: assert property (
    s_reg_frame ##0 (fis_error == 8'h00) |-> fis_status == STATE_FLAGS_RESET)
    else $error("clean register frame with wrong status byte");
  a_offer_held: assert property (
    $rose(cmd_valid) |-> cmd_valid throughout (##[0:8] cmd_ready))
    else $error("command offer dropped before it was taken");
  a_cmd_stable: assert property (
    $changed(cmd) |-> $rose(cmd_valid))
    else $error("command image changed outside a new offer");
endmodule
`default_nettype wire

//--- sim/test_queued_log_write_command.sv
// Purpose: Self-checking bench joining controller and device over the link.
// Assumes: One clock at 200 MHz; the bench plays the bus master and user side.
// Notes: Expected values are constants worked out by hand.
`timescale 1ns/1ps
`default_nettype none
module test_queued_log_write_command;
  import queued_cmd_pkg::*;
  logic clk_i, rst_n_i; // Clock and reset.
  logic [31:0] haddr, hwdata, hrdata, rd; // Bus address, data and scratch.
  logic [1:0] htrans; // Transfer type.
  logic hwrite, hready, irq, hresp; // Bus write flag, ready, interrupt, response.
  logic job_valid, job_accept, job_error, done_valid; // User handshake.
  logic [4:0] job_tag, done_tag; // Tags of job and finished job.
  logic [15:0] job_count; // Decoded count.
  logic [47:0] job_lba; // Decoded log address.
  logic [7:0] job_code, err_flags, state_flags; // Error code and reported bytes.
  logic [31:0] outstanding, act_seen; // Open tags and tags reported done.
  shadow_t last_cmd; // Image seen at the last take.
  logic [7:0] ops [6] = '{8'h65, 8'h64, 8'h64, 8'h64, 8'h64, 8'h64}; // Opcodes of the aborted commands; only the first is foreign.
  logic [4:0] subs [6] = '{5'h02, 5'h00, 5'h01, 5'h03, 5'h0F, 5'h1F}; // Subcodes of the aborted commands; all but the first are reserved.
  int num_errors = 0; // Mismatches.
  int checked = 0; // Comparisons.
  queued_link_if u_queued_link_if ();
  queued_log_host u_queued_log_host (.clk_i(clk_i), .rst_n_i(rst_n_i), .hsel_i(1'b1),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'b010),
    .hready_i(hready), .hwdata_i(hwdata), .hrdata_o(hrdata), .hreadyout_o(hready),
    .hresp_o(hresp), .irq_o(irq), .link(u_queued_link_if.host));
  queued_log_dev u_queued_log_dev (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .link(u_queued_link_if.device), .job_valid_o(job_valid), .job_tag_o(job_tag),
    .job_count_o(job_count), .job_lba_o(job_lba), .job_accept_i(job_accept),
    .job_error_i(job_error), .job_error_code_i(job_code), .done_valid_i(done_valid),
    .done_tag_i(done_tag), .outstanding_o(outstanding), .error_flags_o(err_flags),
    .device_state_flags_o(state_flags));
  queued_log_sva u_queued_log_sva (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .cmd_valid(u_queued_link_if.cmd_valid), .cmd_ready(u_queued_link_if.cmd_ready),
    .cmd(u_queued_link_if.cmd), .fis_valid(u_queued_link_if.fis_valid),
    .fis_kind(u_queued_link_if.fis_kind), .fis_status(u_queued_link_if.fis_status),
    .fis_error(u_queued_link_if.fis_error), .fis_act(u_queued_link_if.fis_act));
  // The clock toggles every half period of 2.5 ns.
  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  // Watches the wire: keeps the last taken image and all reported tags.
  always @(posedge clk_i)
  begin
    if (u_queued_link_if.cmd_valid && u_queued_link_if.cmd_ready)
      last_cmd <= u_queued_link_if.cmd;
    if (!rst_n_i)
      act_seen <= '0;
    else if (u_queued_link_if.fis_valid && u_queued_link_if.fis_kind == FIS_SET_BITS)
      act_seen <= act_seen | u_queued_link_if.fis_act;
  end
  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Compares one value and reports a mismatch at once.
  task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One single word transfer; each phase is held until hready is sampled high.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    haddr <= {24'h000000, a};
    hwrite <= wr;
    htrans <= 2'b10;
    @(posedge clk_i);
    while (hready !== 1'b1) @(posedge clk_i);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk_i);
    while (hready !== 1'b1) @(posedge clk_i);
    rd = hrdata;
  endtask
  // Reads a register and compares the masked word.
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk("register read", {16'h0000, exp}, {16'h0000, rd & m});
  endtask
  // Loads the command register and starts the controller.
  task automatic issue(input logic [4:0] t, input logic [4:0] s, input logic [7:0] op);
    bus(1'b1, OFS_CMD, {8'h00, op, 3'b000, s, 3'b000, t});
    bus(1'b1, OFS_CTRL, 32'h0000_0001);
  endtask
  // Polls the interrupt status until the given event bit is set.
  task automatic wait_irq(input int b);
    for (int i = 0; i < 30; i++)
    begin
      bus(1'b0, OFS_IRQ_STAT, 32'h0000_0000);
      if (rd[b] === 1'b1)
        return;
    end
    chk("interrupt event", 48'h1, 48'h0);
  endtask
  // Waits a bounded time for the device to offer a decoded job.
  task automatic wait_job();
    for (int i = 0; i < 30 && job_valid !== 1'b1; i++)
      @(posedge clk_i);
    chk("job offered", 48'h1, {47'h0, job_valid});
  endtask
  // Cuts a hang short after far more cycles than the tests need.
  initial
  begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    stop_test();
  end
  // Main sequence of tests.
  initial
  begin
    {haddr, hwdata, htrans, hwrite, job_accept, job_error, job_code} <= '0;
    {done_valid, done_tag} <= '0;
    rst_n_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    chk("state flags", 48'h40, {40'h0, state_flags});
    rchk(OFS_CMD, 32'hFFFF_FFFF, {8'h00, CMD_OPCODE_RESET, 16'h0000});
    rchk(OFS_IRQ_STAT, 32'hFFFF_FFFF, 32'h0000_0000);
    rchk(8'h40, 32'hFFFF_FFFF, 32'h0000_0000);
    chk("bus response", 48'h0, {47'h0, hresp});
    $display("Test reset values done");
    bus(1'b1, OFS_COUNT, 32'h0000_A5C3);
    bus(1'b1, OFS_LBA_LO, 32'h4433_2211);
    bus(1'b1, OFS_LBA_HI, 32'h0000_6655);
    bus(1'b1, OFS_IRQ_EN, 32'h0000_0007);
    for (int i = 0; i < 2; i++)
    begin
      issue(i ? 5'd9 : 5'd5, SUBCMD_WRITE_LOG, OPCODE_SEND_QUEUED);
      wait_job();
      chk("job tag", i ? 48'd9 : 48'd5, {43'h0, job_tag});
      chk("job count", 48'hA5C3, {32'h0, job_count});
      chk("job lba", 48'h6655_4433_2211, job_lba);
      chk("wire count", 48'hA5C3, {32'h0, last_cmd.feat_prev, last_cmd.feat_cur});
      chk("wire lba", 48'h6655_4433_2211, {last_cmd.cylhi_prev, last_cmd.cyllo_prev,
        last_cmd.sec_prev, last_cmd.cylhi_cur, last_cmd.cyllo_cur, last_cmd.sec_cur});
      chk("wire tag", i ? 48'd9 : 48'd5, {43'h0, last_cmd.cnt_cur[7:3]});
      chk("wire subcode", 48'h2, {43'h0, last_cmd.cnt_prev[4:0]});
      chk("wire devhead", 48'h40, {40'h0, last_cmd.devhead & 8'h50});
      job_accept <= 1'b1;
      @(posedge clk_i);
      job_accept <= 1'b0;
      wait_irq(IRQ_ACCEPT);
      chk("irq line", 48'h1, {47'h0, irq});
      rchk(OFS_STATUS, 32'h0001_FFFF, 32'h0000_0040);
      bus(1'b1, OFS_IRQ_CLR, 32'h0000_0007);
    end
    chk("open tags", 48'h220, {16'h0, outstanding});
    $display("Test accepted commands done");
    done_valid <= 1'b1;
    done_tag <= 5'd5;
    @(posedge clk_i);
    done_tag <= 5'd9;
    @(posedge clk_i);
    done_valid <= 1'b0;
    wait_irq(IRQ_DONE);
    rchk(OFS_DONE, 32'hFFFF_FFFF, 32'h0000_0220);
    chk("frame tags", 48'h220, {16'h0, act_seen});
    chk("open tags", 48'h0, {16'h0, outstanding});
    bus(1'b1, OFS_DONE_CLR, 32'hFFFF_FFFF);
    rchk(OFS_DONE, 32'hFFFF_FFFF, 32'h0000_0000);
    bus(1'b1, OFS_IRQ_CLR, 32'h0000_0007);
    $display("Test completions done");
    for (int i = 0; i < 6; i++)
    begin
      issue(5'd1, subs[i], ops[i]);
      wait_irq(IRQ_ERROR);
      rchk(OFS_STATUS, 32'h0000_FF01, 32'h0000_0401);
      chk("no job", 48'h0, {47'h0, job_valid});
      bus(1'b1, OFS_IRQ_CLR, 32'h0000_0007);
    end
    $display("Test aborted commands done");
    bus(1'b1, OFS_IRQ_EN, 32'h0000_0000);
    issue(5'd3, SUBCMD_WRITE_LOG, OPCODE_SEND_QUEUED);
    wait_job();
    job_error <= 1'b1;
    job_code <= 8'h10;
    @(posedge clk_i);
    job_error <= 1'b0;
    wait_irq(IRQ_ERROR);
    chk("masked irq", 48'h0, {47'h0, irq});
    chk("error flags", 48'h10, {40'h0, err_flags});
    rchk(OFS_STATUS, 32'h0000_FF01, 32'h0000_1001);
    bus(1'b1, OFS_IRQ_EN, 32'h0000_0002);
    rchk(OFS_IRQ_EN, 32'hFFFF_FFFF, 32'h0000_0002);
    chk("enabled irq", 48'h1, {47'h0, irq});
    bus(1'b1, OFS_IRQ_CLR, 32'h0000_0007);
    rchk(OFS_IRQ_STAT, 32'hFFFF_FFFF, 32'h0000_0000);
    chk("cleared irq", 48'h0, {47'h0, irq});
    chk("refused tag", 48'h0, {16'h0, outstanding});
    $display("Test refused command done");
    stop_test();
  end
endmodule
`default_nettype wire
